// ===== include/spci_pkg.sv
// Constants and types of the serial port command interpreter.
package spci_pkg;
    localparam logic [15:0] CMD_PORT_CTRL = 16'h10d0;
    localparam logic [15:0] CMD_CANCEL = 16'h112f;
    localparam logic [15:0] CMD_DIAL = 16'h1130;
    localparam logic [15:0] CANCEL_ALL = 16'h0001;
    localparam logic [15:0] CANCEL_READ = 16'h0002;
    localparam logic [15:0] CANCEL_WRITE = 16'h0003;
    localparam logic [15:0] WAIT_NONE = 16'h0000;
    localparam int RTS_BIT = 15;
    localparam int CTS_BIT = 5;
    localparam logic [2:0] HDR_LAST = 3'h5;
    localparam logic [7:0] ESC_CHAR = 8'h2b;
    localparam logic [1:0] ESC_LAST = 2'h2;
    localparam logic [7:0] STR_BYTES_MAX = 8'hfa;
    localparam logic [7:0] WR_BYTES_MIN = 8'h01;
    localparam int STR_WORDS = 125;
    localparam logic [15:0] STAT_OK = 16'h0001;
    localparam logic [15:0] STAT_BAD_CMD = 16'h0002;
    localparam logic [15:0] STAT_BAD_TYPE = 16'h0003;
    localparam logic [15:0] STAT_NOT_SIO = 16'h0004;
    localparam logic [15:0] STAT_BUSY = 16'h0005;
    localparam logic [15:0] STAT_BAD_LEN = 16'h0006;
    localparam logic [15:0] STAT_TIMEOUT = 16'h0007;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SECOND_NS = 1000000000;
    localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        PS_HDR, PS_CODE, PS_PCW, PS_CTYPE, PS_TMO, PS_LEN, PS_STR, PS_SKIP
    } spci_parse_t;

    typedef enum logic [2:0] {
        DS_IDLE, DS_ESC, DS_STR, DS_RESP, DS_DONE
    } spci_dial_t;
endpackage

// ===== include/spci_dial_if.sv
// Link between the command parser and the dial sequencer.
`timescale 1ns/100ps
interface spci_dial_if;
    logic start;
    logic abort;
    logic [7:0] nbytes;
    logic [15:0] tmo_sec;
    logic [6:0] rd_addr;
    logic [15:0] rd_data;
    logic modem_resp;
    logic busy;
    logic done;
    logic [15:0] result;
    logic ack;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_ready;

    modport parser (output start, abort, nbytes, tmo_sec, rd_data, modem_resp, ack, tx_ready,
                    input rd_addr, busy, done, result, tx_byte, tx_valid);
    modport dialer (input start, abort, nbytes, tmo_sec, rd_data, modem_resp, ack, tx_ready,
                    output rd_addr, busy, done, result, tx_byte, tx_valid);
endinterface

// ===== logic/spci_dial_tx.sv
// Dial sequencer: escape sequence, packed command string, response wait.
`timescale 1ns/100ps
module spci_dial_tx #(
    parameter int SEC_CYCLES = spci_pkg::SEC_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    spci_dial_if.dialer dl
);
    spci_pkg::spci_dial_t st_r, st_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic [7:0] byte_r, byte_nxt;
    logic valid_r, valid_nxt;
    logic [15:0] res_r, res_nxt;
    logic [15:0] sec_r, sec_nxt;
    logic [31:0] tick_r, tick_nxt;
    logic [7:0] str_byte;

    // Earlier character sits in the low byte of each word.
    assign str_byte = idx_r[0] ? dl.rd_data[15:8] : dl.rd_data[7:0];
    assign dl.rd_addr = idx_r[7:1];
    assign dl.busy = (st_r != spci_pkg::DS_IDLE);
    assign dl.done = (st_r == spci_pkg::DS_DONE);
    assign dl.result = res_r;
    assign dl.tx_byte = byte_r;
    assign dl.tx_valid = valid_r;

    always_comb begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        byte_nxt = byte_r;
        valid_nxt = valid_r;
        res_nxt = res_r;
        sec_nxt = sec_r;
        tick_nxt = tick_r;
        if (dl.abort && st_r != spci_pkg::DS_IDLE) begin
            // An aborted dial stops mid-string and reports nothing.
            st_nxt = spci_pkg::DS_IDLE;
            valid_nxt = 1'b0;
        end else begin
            case (st_r)
                spci_pkg::DS_IDLE: begin
                    if (dl.start) begin
                        st_nxt = spci_pkg::DS_ESC;
                        idx_nxt = 8'h00;
                        byte_nxt = spci_pkg::ESC_CHAR;
                        valid_nxt = 1'b1;
                    end
                end
                spci_pkg::DS_ESC: begin
                    if (dl.tx_ready) begin
                        if (idx_r[1:0] == spci_pkg::ESC_LAST) begin
                            idx_nxt = 8'h00;
                            valid_nxt = 1'b0;
                            st_nxt = spci_pkg::DS_STR;
                        end else begin
                            idx_nxt = idx_r + 8'h01;
                        end
                    end
                end
                spci_pkg::DS_STR: begin
                    if (!valid_r) begin
                        if (idx_r == dl.nbytes) begin
                            st_nxt = spci_pkg::DS_RESP;
                            sec_nxt = 16'h0000;
                            tick_nxt = 32'h0;
                        end else begin
                            byte_nxt = str_byte;
                            valid_nxt = 1'b1;
                        end
                    end else if (dl.tx_ready) begin
                        valid_nxt = 1'b0;
                        idx_nxt = idx_r + 8'h01;
                    end
                end
                spci_pkg::DS_RESP: begin
                    if (dl.modem_resp) begin
                        res_nxt = spci_pkg::STAT_OK;
                        st_nxt = spci_pkg::DS_DONE;
                    end else if (tick_r == 32'(SEC_CYCLES - 1)) begin
                        tick_nxt = 32'h0;
                        sec_nxt = sec_r + 16'h0001;
                        if (sec_r + 16'h0001 >= dl.tmo_sec) begin
                            res_nxt = spci_pkg::STAT_TIMEOUT;
                            st_nxt = spci_pkg::DS_DONE;
                        end
                    end else begin
                        tick_nxt = tick_r + 32'h1;
                    end
                end
                spci_pkg::DS_DONE: begin
                    if (dl.ack) begin
                        st_nxt = spci_pkg::DS_IDLE;
                    end
                end
                default: st_nxt = spci_pkg::DS_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= spci_pkg::DS_IDLE;
            idx_r <= 8'h00;
            byte_r <= 8'h00;
            valid_r <= 1'b0;
            res_r <= 16'h0000;
            sec_r <= 16'h0000;
            tick_r <= 32'h0;
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            byte_r <= byte_nxt;
            valid_r <= valid_nxt;
            res_r <= res_nxt;
            sec_r <= sec_nxt;
            tick_r <= tick_nxt;
        end
    end
endmodule

// ===== logic/spci_top.sv
// Serial port command interpreter: block parser, RTS control, cancel and dial start.
`timescale 1ns/100ps
module spci_top #(
    parameter int SEC_CYCLES = spci_pkg::SEC_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_word_valid,
    input wire logic i_word_first,
    input wire logic [15:0] i_word,
    input wire logic i_sio_mode,
    input wire logic i_duplex_p2p,
    input wire logic i_tx_active,
    input wire logic i_cts_present,
    input wire logic i_cts,
    input wire logic i_modem_resp,
    input wire logic i_tx_ready,
    input wire logic [7:0] i_wr_len,
    output logic o_rts_cmd,
    output logic o_tx_drv_en,
    output logic o_rts_line,
    output logic o_cancel_read,
    output logic o_cancel_write,
    output logic o_clear_to_send_flag,
    output logic o_wr_len_ok,
    output logic [7:0] o_tx_byte,
    output logic o_tx_valid,
    output logic o_stat_valid,
    output logic [15:0] o_stat_word,
    output logic [15:0] o_stat_type,
    output logic [15:0] o_stat_addr,
    output logic o_immediate_return_flag
);
    // ******************************************************************
    // Block parser
    // ******************************************************************
    spci_dial_if dif ();

    spci_pkg::spci_parse_t st_r, st_nxt;
    logic [2:0] hidx_r, hidx_nxt;
    logic [15:0] styp_r, styp_nxt;
    logic [15:0] sadr_r, sadr_nxt;
    logic imm_r, imm_nxt;
    logic rts_r, rts_nxt;
    logic crd_r, crd_nxt;
    logic cwr_r, cwr_nxt;
    logic sv_r, sv_nxt;
    logic [15:0] sw_r, sw_nxt;
    logic [15:0] ot_r, ot_nxt;
    logic [15:0] oa_r, oa_nxt;
    logic on_r, on_nxt;
    logic [15:0] tmo_r, tmo_nxt;
    logic [7:0] nb_r, nb_nxt;
    logic [6:0] widx_r, widx_nxt;
    logic start_r, start_nxt;
    logic [15:0] dtyp_r, dtyp_nxt;
    logic [15:0] dadr_r, dadr_nxt;
    logic dnw_r, dnw_nxt;
    logic drv_r, line_r, cts_r, wok_r;
    localparam int STR_WORDS_LOCAL = spci_pkg::STR_WORDS;
    logic [15:0] str_mem [STR_WORDS_LOCAL];
    logic str_we;

    // Replies are queued as a single status slot; parser replies take it first.
    task automatic reply(input logic [15:0] code);
        sv_nxt = 1'b1;
        sw_nxt = code;
        ot_nxt = styp_r;
        oa_nxt = sadr_r;
        on_nxt = imm_r;
    endtask

    always_comb begin
        st_nxt = st_r;
        hidx_nxt = hidx_r;
        styp_nxt = styp_r;
        sadr_nxt = sadr_r;
        imm_nxt = imm_r;
        rts_nxt = rts_r;
        crd_nxt = 1'b0;
        cwr_nxt = 1'b0;
        sv_nxt = 1'b0;
        sw_nxt = sw_r;
        ot_nxt = ot_r;
        oa_nxt = oa_r;
        on_nxt = on_r;
        tmo_nxt = tmo_r;
        nb_nxt = nb_r;
        widx_nxt = widx_r;
        start_nxt = 1'b0;
        dtyp_nxt = dtyp_r;
        dadr_nxt = dadr_r;
        dnw_nxt = dnw_r;
        str_we = 1'b0;
        dif.ack = 1'b0;
        if (i_word_valid && i_word_first) begin
            st_nxt = spci_pkg::PS_HDR;
            hidx_nxt = 3'h1;
        end else if (i_word_valid) begin
            case (st_r)
                spci_pkg::PS_HDR: begin
                    // Word 2 is wait mode, words 3 and 4 locate the status word.
                    case (hidx_r)
                        3'h1: imm_nxt = (i_word == spci_pkg::WAIT_NONE);
                        3'h2: styp_nxt = i_word;
                        3'h3: sadr_nxt = i_word;
                        default: ;
                    endcase
                    if (hidx_r == spci_pkg::HDR_LAST) begin
                        st_nxt = spci_pkg::PS_CODE;
                    end
                    hidx_nxt = hidx_r + 3'h1;
                end
                spci_pkg::PS_CODE: begin
                    st_nxt = spci_pkg::PS_SKIP;
                    case (i_word)
                        spci_pkg::CMD_PORT_CTRL: st_nxt = spci_pkg::PS_PCW;
                        spci_pkg::CMD_CANCEL: st_nxt = spci_pkg::PS_CTYPE;
                        spci_pkg::CMD_DIAL: begin
                            if (!i_sio_mode) begin
                                reply(spci_pkg::STAT_NOT_SIO);
                            end else if (dif.busy) begin
                                reply(spci_pkg::STAT_BUSY);
                            end else begin
                                st_nxt = spci_pkg::PS_TMO;
                            end
                        end
                        default: reply(spci_pkg::STAT_BAD_CMD);
                    endcase
                end
                spci_pkg::PS_PCW: begin
                    rts_nxt = i_word[spci_pkg::RTS_BIT];
                    reply(spci_pkg::STAT_OK);
                    st_nxt = spci_pkg::PS_SKIP;
                end
                spci_pkg::PS_CTYPE: begin
                    st_nxt = spci_pkg::PS_SKIP;
                    // Cancels only flag the engines; buffers and port setup stay intact.
                    case (i_word)
                        spci_pkg::CANCEL_ALL: begin
                            crd_nxt = 1'b1;
                            cwr_nxt = 1'b1;
                            reply(spci_pkg::STAT_OK);
                        end
                        spci_pkg::CANCEL_READ: begin
                            crd_nxt = 1'b1;
                            reply(spci_pkg::STAT_OK);
                        end
                        spci_pkg::CANCEL_WRITE: begin
                            cwr_nxt = 1'b1;
                            reply(spci_pkg::STAT_OK);
                        end
                        default: reply(spci_pkg::STAT_BAD_TYPE);
                    endcase
                end
                spci_pkg::PS_TMO: begin
                    tmo_nxt = i_word;
                    st_nxt = spci_pkg::PS_LEN;
                end
                spci_pkg::PS_LEN: begin
                    widx_nxt = 7'h00;
                    nb_nxt = i_word[7:0];
                    if (i_word == 16'h0000 || i_word > 16'(spci_pkg::STR_BYTES_MAX)) begin
                        reply(spci_pkg::STAT_BAD_LEN);
                        st_nxt = spci_pkg::PS_SKIP;
                    end else begin
                        st_nxt = spci_pkg::PS_STR;
                    end
                end
                spci_pkg::PS_STR: begin
                    str_we = 1'b1;
                    widx_nxt = widx_r + 7'h01;
                    if ({widx_r, 1'b1} >= nb_r - 8'h01) begin
                        // Hang-up strings use the same path as any other dial.
                        start_nxt = 1'b1;
                        dtyp_nxt = styp_r;
                        dadr_nxt = sadr_r;
                        dnw_nxt = imm_r;
                        st_nxt = spci_pkg::PS_SKIP;
                    end
                end
                spci_pkg::PS_SKIP: ;
                default: st_nxt = spci_pkg::PS_SKIP;
            endcase
        end
        if (!sv_nxt && dif.done) begin
            dif.ack = 1'b1;
            sv_nxt = 1'b1;
            sw_nxt = dif.result;
            ot_nxt = dtyp_r;
            oa_nxt = dadr_r;
            on_nxt = dnw_r;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= spci_pkg::PS_SKIP;
            hidx_r <= 3'h0;
            styp_r <= 16'h0000;
            sadr_r <= 16'h0000;
            imm_r <= 1'b1;
            rts_r <= 1'b0;
            crd_r <= 1'b0;
            cwr_r <= 1'b0;
            sv_r <= 1'b0;
            sw_r <= 16'h0000;
            ot_r <= 16'h0000;
            oa_r <= 16'h0000;
            on_r <= 1'b0;
            tmo_r <= 16'h0000;
            nb_r <= 8'h00;
            widx_r <= 7'h00;
            start_r <= 1'b0;
            dtyp_r <= 16'h0000;
            dadr_r <= 16'h0000;
            dnw_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            hidx_r <= hidx_nxt;
            styp_r <= styp_nxt;
            sadr_r <= sadr_nxt;
            imm_r <= imm_nxt;
            rts_r <= rts_nxt;
            crd_r <= crd_nxt;
            cwr_r <= cwr_nxt;
            sv_r <= sv_nxt;
            sw_r <= sw_nxt;
            ot_r <= ot_nxt;
            oa_r <= oa_nxt;
            on_r <= on_nxt;
            tmo_r <= tmo_nxt;
            nb_r <= nb_nxt;
            widx_r <= widx_nxt;
            start_r <= start_nxt;
            dtyp_r <= dtyp_nxt;
            dadr_r <= dadr_nxt;
            dnw_r <= dnw_nxt;
        end
    end

    // The string store has no reset; words are always written before the dialer reads them.
    always_ff @(posedge i_clock) begin
        if (str_we) begin
            str_mem[widx_r] <= i_word;
        end
    end

    // ******************************************************************
    // Line levels and status
    // ******************************************************************
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            drv_r <= 1'b0;
            line_r <= 1'b0;
            cts_r <= 1'b1;
            wok_r <= 1'b0;
        end else begin
            drv_r <= i_duplex_p2p | i_tx_active | o_tx_valid;
            line_r <= rts_r & (i_duplex_p2p | i_tx_active | o_tx_valid);
            cts_r <= !i_cts_present | i_cts;
            wok_r <= (i_wr_len >= spci_pkg::WR_BYTES_MIN) &&
                     (i_wr_len <= spci_pkg::STR_BYTES_MAX);
        end
    end

    // ******************************************************************
    // Dial sequencer
    // ******************************************************************
    assign dif.start = start_r;
    assign dif.abort = cwr_r;
    assign dif.nbytes = nb_r;
    assign dif.tmo_sec = tmo_r;
    assign dif.rd_data = str_mem[dif.rd_addr];
    assign dif.modem_resp = i_modem_resp;
    assign dif.tx_ready = i_tx_ready;

    spci_dial_tx #(.SEC_CYCLES(SEC_CYCLES)) u_dial (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .dl(dif.dialer)
    );

    assign o_rts_cmd = rts_r;
    assign o_tx_drv_en = drv_r;
    assign o_rts_line = line_r;
    assign o_cancel_read = crd_r;
    assign o_cancel_write = cwr_r;
    assign o_clear_to_send_flag = cts_r;
    assign o_wr_len_ok = wok_r;
    assign o_tx_byte = dif.tx_byte;
    assign o_tx_valid = dif.tx_valid;
    assign o_stat_valid = sv_r;
    assign o_stat_word = sw_r;
    assign o_stat_type = ot_r;
    assign o_stat_addr = oa_r;
    assign o_immediate_return_flag = on_r;
endmodule

// ===== verification/spci_top_asserts.sv
// Port-level assertions and covers for the serial port command interpreter.
`timescale 1ns/100ps
module spci_chk #(
    parameter int SEC_CYCLES = spci_pkg::SEC_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_duplex_p2p,
    input wire logic i_tx_active,
    input wire logic i_cts_present,
    input wire logic i_cts,
    input wire logic [7:0] i_wr_len,
    input wire logic i_tx_ready,
    input wire logic o_rts_cmd,
    input wire logic o_tx_drv_en,
    input wire logic o_rts_line,
    input wire logic o_cancel_read,
    input wire logic o_cancel_write,
    input wire logic o_clear_to_send_flag,
    input wire logic o_wr_len_ok,
    input wire logic [7:0] o_tx_byte,
    input wire logic o_tx_valid,
    input wire logic o_stat_valid,
    input wire logic [15:0] o_stat_word
);
    // A long idle gap on the byte stream marks a new dial, so the count restarts.
    logic rst_q;
    logic [2:0] idle_cnt;
    logic [1:0] hs_cnt;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_q <= 1'b0;
            idle_cnt <= 3'h7;
            hs_cnt <= 2'h0;
        end else begin
            rst_q <= 1'b1;
            idle_cnt <= o_tx_valid ? 3'h0 : ((idle_cnt == 3'h7) ? idle_cnt : idle_cnt + 3'h1);
            if (!o_tx_valid && idle_cnt >= 3'h4) begin
                hs_cnt <= 2'h0;
            end else if (o_tx_valid && i_tx_ready && hs_cnt != 2'h3) begin
                hs_cnt <= hs_cnt + 2'h1;
            end
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_b);
    AST_RTS_LINE:
    assert property (rst_q |-> o_rts_line == ($past(o_rts_cmd) && o_tx_drv_en))
        else $error("line level differs from command and driver");
    AST_DRV_EN:
    assert property (rst_q |-> o_tx_drv_en == $past(i_duplex_p2p || i_tx_active || o_tx_valid))
        else $error("driver enable wrong for duplex mode");
    AST_CTS_FLAG:
    assert property (rst_q |-> o_clear_to_send_flag == $past(!i_cts_present || i_cts))
        else $error("clear to send flag wrong");
    AST_WR_LEN:
    assert property (rst_q |-> o_wr_len_ok == $past(i_wr_len >= spci_pkg::WR_BYTES_MIN &&
        i_wr_len <= spci_pkg::STR_BYTES_MAX))
        else $error("write length check wrong");
    AST_RTS_CHANGE:
    assert property (rst_q && $changed(o_rts_cmd) |-> o_stat_valid &&
        o_stat_word == spci_pkg::STAT_OK)
        else $error("commanded level moved without a port control");
    AST_CANCEL_OK:
    assert property (o_cancel_read || o_cancel_write |-> o_stat_valid &&
        o_stat_word == spci_pkg::STAT_OK ##1 !o_cancel_read && !o_cancel_write)
        else $error("cancel pulse without ok status or too long");
    AST_CANCEL_HALT:
    assert property (o_cancel_write |=> !o_tx_valid)
        else $error("transmission kept going after cancel");
    AST_ESC_FIRST:
    assert property (o_tx_valid && hs_cnt != 2'h3 |-> o_tx_byte == spci_pkg::ESC_CHAR)
        else $error("dial did not open with escape bytes");
    AST_REFUSE_QUIET:
    assert property (o_stat_valid && (o_stat_word == spci_pkg::STAT_BAD_CMD ||
        o_stat_word == spci_pkg::STAT_BAD_TYPE) |->
        !o_cancel_read && !o_cancel_write && $stable(o_rts_cmd))
        else $error("refused block caused port action");
    cover property (o_rts_line);
    cover property (o_cancel_write && o_cancel_read);
    cover property (o_tx_valid && !i_tx_ready);
    cover property (o_stat_valid && o_stat_word == spci_pkg::STAT_TIMEOUT);
endmodule
bind spci_top spci_chk #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.*);

// ===== verification/spci_modem_model.sv
// Behavioural modem on the far side of the dial byte stream.
`timescale 1ns/100ps
module spci_modem_model (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_tx_valid,
    input wire logic i_slow,
    input wire logic i_answer,
    output logic o_tx_ready,
    output logic o_modem_resp,
    output logic o_rx_stb,
    output logic [7:0] o_rx_byte
);
    // The modem answers only after the stream has been quiet for eight cycles.
    logic [1:0] ph;
    logic [3:0] idle;
    logic seen;
    assign o_rx_stb = i_tx_valid && o_tx_ready;
    assign o_rx_byte = i_tx_byte;
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ph <= 2'h0;
            idle <= 4'h0;
            seen <= 1'b0;
            o_tx_ready <= 1'b0;
            o_modem_resp <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            o_tx_ready <= !i_slow || ph == 2'h3;
            idle <= o_rx_stb ? 4'h0 : ((idle == 4'hf) ? idle : idle + 4'h1);
            seen <= o_rx_stb || (seen && !o_modem_resp);
            o_modem_resp <= i_answer && seen && idle == 4'h8;
        end
    end
endmodule

// ===== verification/spci_top_test.sv
// Self-checking bench for the serial port command interpreter.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module spci_top_test;
    logic i_clock = 0, i_rst_b = 0, i_word_valid = 0, i_word_first = 0, i_sio_mode = 1;
    logic i_duplex_p2p = 0, i_tx_active = 0, i_cts_present = 0, i_cts = 0;
    logic [15:0] i_word = 0, w, htype, haddr;
    logic [7:0] i_wr_len = 0, o_tx_byte, rx_byte, bx;
    logic i_modem_resp, i_tx_ready, rx_stb, slow = 0, answer = 0, ign = 0, hwait;
    logic o_rts_cmd, o_tx_drv_en, o_rts_line, o_cancel_read, o_cancel_write, o_wr_len_ok;
    logic o_clear_to_send_flag, o_tx_valid, o_stat_valid, o_immediate_return_flag;
    logic [15:0] o_stat_word, o_stat_type, o_stat_addr;
    logic [48:0] stat_q[$], sx, pend;
    logic [7:0] byte_q[$];
    int fails = 0, tests_run = 0, seed = 32'h4842, k;
    spci_top #(.SEC_CYCLES(10)) DUT (.*);
    spci_modem_model u_modem (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_tx_byte(o_tx_byte),
        .i_tx_valid(o_tx_valid), .i_slow(slow), .i_answer(answer), .o_tx_ready(i_tx_ready),
        .o_modem_resp(i_modem_resp), .o_rx_stb(rx_stb), .o_rx_byte(rx_byte));
    always #20 i_clock = ~i_clock;
    task tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task put(input logic [15:0] v, input logic f);
        i_word = v;
        i_word_first = f;
        i_word_valid = 1'b1;
        @(posedge i_clock);
        #1;
    endtask
    task head(input logic [15:0] len);
        hwait = 1'($random(seed));
        htype = 16'($random(seed));
        haddr = 16'($random(seed));
        put(len, 1'b1);
        put(hwait ? spci_pkg::WAIT_NONE : 16'h0001, 1'b0);
        put(htype, 1'b0);
        put(haddr, 1'b0);
        put(16'h0000, 1'b0);
        put(16'h0000, 1'b0);
    endtask
    task exp(input logic [15:0] st);
        stat_q.push_back({hwait, htype, haddr, st});
    endtask
    task drain();
        int j;
        for (j = 0; j < 3000 && (stat_q.size() + byte_q.size()) > 0; j++) @(posedge i_clock);
        `CHK("queues_empty", 1'b1, 1'((stat_q.size() + byte_q.size()) == 0))
        @(posedge i_clock);
        #1;
    endtask
    task dial(input int n, input logic [15:0] tmo, input logic [15:0] st, input logic pb);
        int j;
        head(16'(3 + (n + 1) / 2));
        if (st == spci_pkg::STAT_NOT_SIO || st == spci_pkg::STAT_BUSY) exp(st);
        put(spci_pkg::CMD_DIAL, 1'b0);
        put(tmo, 1'b0);
        if (st == spci_pkg::STAT_BAD_LEN) exp(st);
        put(16'(n), 1'b0);
        if (pb) repeat (3) byte_q.push_back(spci_pkg::ESC_CHAR);
        for (j = 0; j < (n + 1) / 2 && st != spci_pkg::STAT_BAD_LEN &&
            st != spci_pkg::STAT_NOT_SIO && st != spci_pkg::STAT_BUSY; j++) begin
            w = 16'($random(seed));
            if (pb) byte_q.push_back(w[7:0]);
            if (pb && 2 * j + 1 < n) byte_q.push_back(w[15:8]);
            put(w, 1'b0);
        end
        if (st == 16'h0000) pend = {hwait, htype, haddr, spci_pkg::STAT_OK};
        if (st == spci_pkg::STAT_OK || st == spci_pkg::STAT_TIMEOUT) exp(st);
    endtask
    always @(negedge i_clock) begin
        if (o_stat_valid === 1'b1) begin
            if (stat_q.size() == 0) `CHK("status_extra", 1'b0, 1'b1)
            else begin
                sx = stat_q.pop_front();
                `CHK("status", sx, {o_immediate_return_flag, o_stat_type, o_stat_addr, o_stat_word})
            end
        end
        if (rx_stb === 1'b1 && !ign) begin
            if (byte_q.size() == 0) `CHK("byte_extra", 1'b0, 1'b1)
            else begin
                bx = byte_q.pop_front();
                `CHK("tx_byte", bx, rx_byte)
            end
        end
    end
    initial begin
        #(40 * 40000);
        $display("mismatch watchdog expected done seen hang");
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge i_clock);
        #1;
        i_rst_b = 1'b1;
        for (k = 0; k < 8; k++) begin
            i_duplex_p2p = k[0];
            i_tx_active = k[2];
            w = {k[1], 15'($random(seed))};
            head(16'h0002);
            put(spci_pkg::CMD_PORT_CTRL, 1'b0);
            exp(spci_pkg::STAT_OK);
            put(w, 1'b0);
            `CHK("rts_cmd", w[15], o_rts_cmd)
            @(posedge i_clock);
            #1;
            `CHK("rts_line", w[15] & (k[0] | k[2]), o_rts_line)
        end
        head(16'h0001);
        exp(spci_pkg::STAT_BAD_CMD);
        put(16'h10cd, 1'b0);
        for (k = 1; k < 6; k++) begin
            w = 16'(k % 5);
            head(16'h0002);
            put(spci_pkg::CMD_CANCEL, 1'b0);
            exp((w >= 16'h0001 && w <= 16'h0003) ? spci_pkg::STAT_OK : spci_pkg::STAT_BAD_TYPE);
            put(w, 1'b0);
            `CHK("cancel_read", 1'(w == 16'h0001 || w == 16'h0002), o_cancel_read)
            `CHK("cancel_write", 1'(w == 16'h0001 || w == 16'h0003), o_cancel_write)
        end
        i_sio_mode = 1'b0;
        dial(2, 16'h0003, spci_pkg::STAT_NOT_SIO, 1'b0);
        i_sio_mode = 1'b1;
        dial(0, 16'h0003, spci_pkg::STAT_BAD_LEN, 1'b0);
        dial(251, 16'h0003, spci_pkg::STAT_BAD_LEN, 1'b0);
        answer = 1'b1;
        slow = 1'b1;
        dial(5, 16'h0003, spci_pkg::STAT_OK, 1'b1);
        drain();
        slow = 1'b0;
        dial(250, 16'h0003, spci_pkg::STAT_OK, 1'b1);
        drain();
        answer = 1'b0;
        dial(3, 16'h0001, spci_pkg::STAT_TIMEOUT, 1'b1);
        drain();
        answer = 1'b1;
        slow = 1'b1;
        dial(6, 16'h0003, 16'h0000, 1'b1);
        dial(2, 16'h0003, spci_pkg::STAT_BUSY, 1'b0);
        stat_q.push_back(pend);
        drain();
        ign = 1'b1;
        dial(20, 16'h0003, 16'h0000, 1'b0);
        repeat (12) @(posedge i_clock);
        #1;
        head(16'h0002);
        put(spci_pkg::CMD_CANCEL, 1'b0);
        exp(spci_pkg::STAT_OK);
        put(spci_pkg::CANCEL_WRITE, 1'b0);
        @(posedge i_clock);
        #1;
        `CHK("tx_valid", 1'b0, o_tx_valid)
        repeat (80) @(posedge i_clock);
        #1;
        ign = 1'b0;
        for (k = 0; k < 8; k++) begin
            i_cts_present = k[0];
            i_cts = k[1];
            i_wr_len = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : (k == 2) ? 8'hfa :
                (k == 3) ? 8'hfb : 8'($random(seed));
            @(posedge i_clock);
            #1;
            `CHK("cts_flag", ~k[0] | k[1], o_clear_to_send_flag)
            `CHK("wr_len_ok", 1'(i_wr_len >= 8'h01 && i_wr_len <= 8'hfa), o_wr_len_ok)
        end
        drain();
        tally_and_finish();
    end
endmodule
